// file: include/tin_sel_pkg.sv
// Constants for the timer input source selector
package tin_sel_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_INT_SRC   = 32'hFF770418;
  localparam logic [31:0] ADDR_CASCADE   = 32'hFF771000;
  localparam logic [31:0] ADDR_RX_SRC    = 32'hFF771004;
  localparam logic [31:0] ADDR_STAMP_SRC = 32'hFF772014;
  localparam logic [31:0] ADDR_IN_STATUS = 32'hFF772020;

  // Reset values
  localparam logic [7:0] RST_SEL = 8'h00;

  // Writable bits per register
  localparam logic [7:0] MASK_INT_SRC   = 8'h03;
  localparam logic [7:0] MASK_CASCADE   = 8'hFF;
  localparam logic [7:0] MASK_RX_SRC    = 8'h4F;
  localparam logic [7:0] MASK_STAMP_SRC = 8'h3F;

  // Field positions
  localparam int RX_IN0_LSB       = 0;
  localparam int RX_IN1_LSB       = 2;
  localparam int RX_IN2_UART_BIT  = 6;
  localparam int ST_CAN0_BIT      = 0;
  localparam int ST_IN11_BIT      = 1;
  localparam int ST_IN12_BIT      = 2;
  localparam int ST_IN13_BIT      = 3;
  localparam int ST_IN15_BIT      = 5;
  localparam int INT_IN0_BIT      = 0;
  localparam int INT_IN15_BIT     = 1;

  // Two-bit source codes for inputs 0 and 1
  localparam logic [1:0] SRC_STAMP = 2'h1;
  localparam logic [1:0] SRC_ALT   = 2'h3;

  // Register selector
  typedef enum logic [2:0] {
    REG_NONE   = 3'h0,
    REG_INT    = 3'h1,
    REG_CASC   = 3'h3,
    REG_RX     = 3'h2,
    REG_STAMP  = 3'h6,
    REG_STATUS = 3'h7
  } reg_sel_t;

endpackage : tin_sel_pkg

// file: include/tin_sel_if.sv
// Carrier between register file and source multiplexer
`timescale 1ns/1ps
interface tin_sel_if;
  logic [7:0]  interrupt_source_reg;
  logic [7:0]  odd_cascade_reg;
  logic [7:0]  receive_source_reg;
  logic [7:0]  timestamp_source_reg;
  logic [15:0] timer_in;

  modport regs (output interrupt_source_reg, output odd_cascade_reg,
                output receive_source_reg, output timestamp_source_reg,
                input timer_in);
  modport mux  (input interrupt_source_reg, input odd_cascade_reg,
                input receive_source_reg, input timestamp_source_reg,
                output timer_in);
endinterface : tin_sel_if

// file: hdl/tin_source_mux.sv
// Combinational source multiplexers for the sixteen timer inputs
`timescale 1ns/1ps
module tin_source_mux (
  // Selection carrier
  tin_sel_if.mux           sel,
  // Sources
  input  wire logic [15:0] pin_i,
  input  wire logic [3:0]  can_timestamp_out_i,
  input  wire logic        uart2_rx_line_i,
  input  wire logic        uart10_rx_line_i,
  input  wire logic        uart11_rx_line_i,
  input  wire logic        second_timer_ch3_irq_i
);

  logic        input0_second_pick;
  logic        input1_src;
  logic        input15_src;
  logic [15:0] tin;

  // Two-bit source decode used by inputs 0 and 1
  function automatic logic pick2(input logic [1:0] code, input logic pin,
                                 input logic stamp, input logic alt);
    logic r;
    r = pin;
    if (code == tin_sel_pkg::SRC_STAMP) begin
      r = stamp;
    end else if (code == tin_sel_pkg::SRC_ALT) begin
      r = alt;
    end
    return r;
  endfunction : pick2

  always_comb begin
    // Secondary pick for input 0
    input0_second_pick = sel.interrupt_source_reg[tin_sel_pkg::INT_IN0_BIT] ?
                         second_timer_ch3_irq_i : uart10_rx_line_i;
    input1_src = pick2(sel.receive_source_reg[tin_sel_pkg::RX_IN1_LSB +: 2], pin_i[1],
                       can_timestamp_out_i[1], uart11_rx_line_i);
    // Irq pick has priority over stamp pick
    if (sel.interrupt_source_reg[tin_sel_pkg::INT_IN15_BIT]) begin
      input15_src = second_timer_ch3_irq_i;
    end else if (sel.timestamp_source_reg[tin_sel_pkg::ST_IN15_BIT]) begin
      input15_src = can_timestamp_out_i[0];
    end else begin
      input15_src = pin_i[15];
    end
    tin = pin_i;
    tin[0] = pick2(sel.receive_source_reg[tin_sel_pkg::RX_IN0_LSB +: 2], pin_i[0],
                   can_timestamp_out_i[0], input0_second_pick);
    tin[1] = sel.odd_cascade_reg[0] ? tin[0] : input1_src;
    tin[2] = sel.receive_source_reg[tin_sel_pkg::RX_IN2_UART_BIT] ?
             uart2_rx_line_i : pin_i[2];
    tin[3] = sel.odd_cascade_reg[1] ? tin[2] : pin_i[3];
    tin[5] = sel.odd_cascade_reg[2] ? tin[4] : pin_i[5];
    tin[7] = sel.odd_cascade_reg[3] ? tin[6] : pin_i[7];
    tin[9] = sel.odd_cascade_reg[4] ? tin[8] : pin_i[9];
    tin[10] = sel.timestamp_source_reg[tin_sel_pkg::ST_CAN0_BIT] ?
              can_timestamp_out_i[0] : pin_i[10];
    tin[11] = sel.odd_cascade_reg[5] ? tin[10] :
              (sel.timestamp_source_reg[tin_sel_pkg::ST_IN11_BIT] ?
               can_timestamp_out_i[1] : pin_i[11]);
    tin[12] = sel.timestamp_source_reg[tin_sel_pkg::ST_IN12_BIT] ?
              can_timestamp_out_i[2] : pin_i[12];
    tin[13] = sel.odd_cascade_reg[6] ? tin[12] :
              (sel.timestamp_source_reg[tin_sel_pkg::ST_IN13_BIT] ?
               can_timestamp_out_i[3] : pin_i[13]);
    tin[15] = sel.odd_cascade_reg[7] ? tin[14] : input15_src;
  end

  assign sel.timer_in = tin;

endmodule : tin_source_mux

// file: hdl/timer_input_source_selector.sv
// APB register file and registered outputs of the timer input selector
//
// Function
// - Receive register bit 6 picks uart2 receive line for timer input 2.
// - Receive bits 3:2 pick pin, CAN1 stamp or uart11 for input-1 selector.
// - Receive bits 1:0 pick pin, CAN0 stamp or secondary pick for input 0.
// - Interrupt register bit 0 picks uart10 or second timer irq for input 0.
// - Interrupt register bit 1 picks second timer irq for input-15 selector.
// - Stamp register bit 5 picks CAN0 stamp for input-15 selector.
// - Stamp register bit 3 picks CAN3 stamp for input-13 selector.
// - Stamp register bit 2 picks CAN2 stamp for timer input 12.
// - Stamp register bit 1 picks CAN1 stamp for input-11 selector.
// - Stamp register bit 0 picks CAN0 stamp for timer input 10.
// - Selection registers are accessed only as whole bytes.
// - Odd input takes neighbouring even input when its cascade bit is set.
`timescale 1ns/1ps
module timer_input_source_selector (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Sources
  input  wire logic [15:0] pin_i,
  input  wire logic [3:0]  can_timestamp_out_i,
  input  wire logic        uart2_rx_line_i,
  input  wire logic        uart10_rx_line_i,
  input  wire logic        uart11_rx_line_i,
  input  wire logic        second_timer_ch3_irq_i,
  // Timer inputs
  output logic [15:0]      timer_in_o
);

  tin_sel_if sel ();

  logic [7:0]             interrupt_source_r;
  logic [7:0]             odd_cascade_r;
  logic [7:0]             receive_source_r;
  logic [7:0]             timestamp_source_r;
  logic                   pready_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic [15:0]            timer_in_r;
  tin_sel_pkg::reg_sel_t  reg_sel;
  logic                   access;
  logic                   wr_done;
  logic                   byte_ok;
  logic [31:0]            rdata_nxt;

  // Address decode
  function automatic tin_sel_pkg::reg_sel_t decode(input logic [31:0] a);
    tin_sel_pkg::reg_sel_t r;
    case (a)
      tin_sel_pkg::ADDR_INT_SRC:   r = tin_sel_pkg::REG_INT;
      tin_sel_pkg::ADDR_CASCADE:   r = tin_sel_pkg::REG_CASC;
      tin_sel_pkg::ADDR_RX_SRC:    r = tin_sel_pkg::REG_RX;
      tin_sel_pkg::ADDR_STAMP_SRC: r = tin_sel_pkg::REG_STAMP;
      tin_sel_pkg::ADDR_IN_STATUS: r = tin_sel_pkg::REG_STATUS;
      default:                     r = tin_sel_pkg::REG_NONE;
    endcase
    return r;
  endfunction : decode

  assign reg_sel = decode(paddr_i);
  assign access  = psel_i & penable_i;
  // Write needs lane 0 alone, a whole byte
  assign byte_ok = (pstrb_i == 4'h1);
  assign wr_done = access & pready_r & pwrite_i & byte_ok & ~pslverr_r;

  // One wait state, then answer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access & ~pready_r;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_sel)
      tin_sel_pkg::REG_INT:    rdata_nxt[7:0]  = interrupt_source_r;
      tin_sel_pkg::REG_CASC:   rdata_nxt[7:0]  = odd_cascade_r;
      tin_sel_pkg::REG_RX:     rdata_nxt[7:0]  = receive_source_r;
      tin_sel_pkg::REG_STAMP:  rdata_nxt[7:0]  = timestamp_source_r;
      tin_sel_pkg::REG_STATUS: rdata_nxt[15:0] = timer_in_r;
      default:                 rdata_nxt       = 32'h0000_0000;
    endcase
  end

  // Read data and error, captured in first access cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (access & ~pready_r) begin
      prdata_r  <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
      pslverr_r <= (reg_sel == tin_sel_pkg::REG_NONE) |
                   (pwrite_i & ((reg_sel == tin_sel_pkg::REG_STATUS) | ~byte_ok));
    end else begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // Selection registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_source_r <= tin_sel_pkg::RST_SEL;
      odd_cascade_r      <= tin_sel_pkg::RST_SEL;
      receive_source_r   <= tin_sel_pkg::RST_SEL;
      timestamp_source_r <= tin_sel_pkg::RST_SEL;
    end else if (wr_done) begin
      case (reg_sel)
        tin_sel_pkg::REG_INT:
          interrupt_source_r <= pwdata_i[7:0] & tin_sel_pkg::MASK_INT_SRC;
        tin_sel_pkg::REG_CASC:
          odd_cascade_r <= pwdata_i[7:0] & tin_sel_pkg::MASK_CASCADE;
        tin_sel_pkg::REG_RX:
          receive_source_r <= pwdata_i[7:0] & tin_sel_pkg::MASK_RX_SRC;
        tin_sel_pkg::REG_STAMP:
          // Bit 4 stored as written; software keeps it zero
          timestamp_source_r <= pwdata_i[7:0] & tin_sel_pkg::MASK_STAMP_SRC;
        default: ;
      endcase
    end
  end

  assign sel.interrupt_source_reg = interrupt_source_r;
  assign sel.odd_cascade_reg      = odd_cascade_r;
  assign sel.receive_source_reg   = receive_source_r;
  assign sel.timestamp_source_reg = timestamp_source_r;

  tin_source_mux u_mux (
    .sel                    (sel),
    .pin_i                  (pin_i),
    .can_timestamp_out_i    (can_timestamp_out_i),
    .uart2_rx_line_i        (uart2_rx_line_i),
    .uart10_rx_line_i       (uart10_rx_line_i),
    .uart11_rx_line_i       (uart11_rx_line_i),
    .second_timer_ch3_irq_i (second_timer_ch3_irq_i)
  );

  // Output stage of the timer inputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_in_r <= 16'h0000;
    end else begin
      timer_in_r <= sel.timer_in;
    end
  end

  assign pready_o   = pready_r;
  assign prdata_o   = prdata_r;
  assign pslverr_o  = pslverr_r;
  assign timer_in_o = timer_in_r;

endmodule : timer_input_source_selector

// file: test/timer_input_sink.sv
// Model of the timer channels that consume the selected inputs
`timescale 1ns/1ps
module timer_input_sink (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Selected inputs
  input  wire logic [15:0] timer_in_i,
  output logic      [15:0] seen_o
);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) seen_o <= 16'h0000;
    else seen_o <= timer_in_i;
  end
endmodule : timer_input_sink

// file: test/tin_sel_sva.sv
// Checker for the timer input source selector
`timescale 1ns/1ps
module tin_sel_sva (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic [15:0] pin_i,
  input wire logic [3:0]  can_timestamp_out_i,
  input wire logic        uart2_rx_line_i,
  input wire logic        uart10_rx_line_i,
  input wire logic        uart11_rx_line_i,
  input wire logic        second_timer_ch3_irq_i,
  input wire logic [15:0] timer_in_o
);
  logic [7:0]      int_r, cas_r, rx_r, st_r;
  logic            run_r;
  logic [15:0]     e;
  wire logic [3:0] cn = can_timestamp_out_i;
  // Shadow of the stored selections
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {int_r, cas_r, rx_r, st_r} <= 32'h0;
    end else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o) begin
      case (paddr_i)
        tin_sel_pkg::ADDR_INT_SRC:   int_r <= pwdata_i[7:0];
        tin_sel_pkg::ADDR_CASCADE:   cas_r <= pwdata_i[7:0];
        tin_sel_pkg::ADDR_RX_SRC:    rx_r <= pwdata_i[7:0];
        tin_sel_pkg::ADDR_STAMP_SRC: st_r <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end
  // Low in the first cycle after reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
    end
  end
  // Expected source of each input
  always_comb begin
    e = pin_i;
    e[0] = rx_r[0] ? (rx_r[1] ? (int_r[0] ? second_timer_ch3_irq_i : uart10_rx_line_i)
                                : cn[0]) : pin_i[0];
    e[1] = rx_r[2] ? (rx_r[3] ? uart11_rx_line_i : cn[1]) : pin_i[1];
    e[2] = rx_r[6] ? uart2_rx_line_i : pin_i[2];
    e[10] = st_r[0] ? cn[0] : pin_i[10];
    e[11] = st_r[1] ? cn[1] : pin_i[11];
    e[12] = st_r[2] ? cn[2] : pin_i[12];
    e[13] = st_r[3] ? cn[3] : pin_i[13];
    e[15] = int_r[1] ? second_timer_ch3_irq_i : (st_r[5] ? cn[0] : pin_i[15]);
    for (int k = 0; k < 8; k++) if (cas_r[k]) e[2 * k + 1] = e[2 * k];
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i; endsequence
  a_in0_src:
    assert property (run_r |-> timer_in_o[0] == $past(e[0])) else $error("input 0 source");
  a_in1_src:
    assert property (run_r |-> timer_in_o[1] == $past(e[1])) else $error("input 1 source");
  a_in2_src:
    assert property (run_r |-> timer_in_o[2] == $past(e[2])) else $error("input 2 source");
  a_in15_src:
    assert property (run_r |-> timer_in_o[15] == $past(e[15])) else $error("input 15 source");
  a_stamp_src:
    assert property (run_r |-> timer_in_o[13:10] == $past(e[13:10])) else $error("stamp inputs");
  a_all_inputs:
    assert property (run_r |-> timer_in_o == $past(e)) else $error("timer inputs");
  a_part_write:
    assert property (psel_i && penable_i && pready_o && pwrite_i && pstrb_i != 4'h1 |-> pslverr_o)
      else $error("partial write taken");
  a_read_back:
    assert property (pready_o && !pwrite_i && !pslverr_o && paddr_i == tin_sel_pkg::ADDR_RX_SRC
      |-> prdata_o == {24'h0, rx_r & tin_sel_pkg::MASK_RX_SRC}) else $error("read back");
  a_one_wait:
    assert property (setup_s ##1 access_s |-> !pready_o ##1 pready_o) else $error("wait state");
endmodule : tin_sel_sva
bind timer_input_source_selector tin_sel_sva chk (.*);

// file: test/tb_top.sv
// Bench for the timer input source selector
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'h0;
  logic [23:0] src_r = 24'h00FFFF;
  logic        pready_o, pslverr_o, er;
  logic [31:0] prdata_o, rd;
  logic [15:0] timer_in_o, seen;
  int          fails = 0, samples_checked = 0, cycles = 0;
  // Register, data, timer input, source pattern; stamp bit 4 kept zero
  localparam logic [67:0] TBL [16] = '{
    68'hFF771004_01_0_010000, 68'hFF771004_03_0_200000, 68'hFF770418_01_0_800000,
    68'hFF771004_02_0_000001, 68'hFF771004_04_1_020000, 68'hFF771004_0C_1_400000,
    68'hFF771004_48_1_000002, 68'hFF771004_40_2_100000, 68'hFF772014_01_A_010000,
    68'hFF772014_02_B_020000, 68'hFF772014_04_C_040000, 68'hFF772014_08_D_080000,
    68'hFF772014_20_F_010000, 68'hFF770418_02_F_800000, 68'hFF771000_01_1_000001,
    68'hFF771000_80_F_004000};
  always #10 sys_clk_i = ~sys_clk_i;
  timer_input_source_selector dut (.*, .pin_i(src_r[15:0]), .can_timestamp_out_i(src_r[19:16]),
    .uart2_rx_line_i(src_r[20]), .uart10_rx_line_i(src_r[21]), .uart11_rx_line_i(src_r[22]),
    .second_timer_ch3_irq_i(src_r[23]));
  timer_input_sink sink (.sys_clk_i, .rst_i, .timer_in_i(timer_in_o), .seen_o(seen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    pstrb_i <= s;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task settle(input logic [3:0] k, input logic v);
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, seen[k]}, {31'h0, v});
  endtask : settle
  task t_reset(input logic pulse);
    if (pulse) begin
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      src_r <= 24'h00FFFF;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, TBL[i][67:36], 8'h00, 4'h0);
      chk(rd, 32'h0);
    end
    chk({16'h0, seen}, 32'h0000FFFF);
    apb(1'b0, tin_sel_pkg::ADDR_IN_STATUS, 8'h00, 4'h0);
    chk(rd, 32'h0000FFFF);
  endtask : t_reset
  task t_refuse;
    apb(1'b1, 32'hFF771004, 8'h40, 4'h3);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 32'hFF771004, 8'h00, 4'h0);
    chk(rd, 32'h0);
    apb(1'b0, 32'hFF771008, 8'h00, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_refuse
  task t_routes;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk_i);
      src_r <= TBL[i][23:0];
      apb(1'b1, TBL[i][67:36], TBL[i][35:28], 4'h1);
      chk({31'h0, er}, 32'h0);
      apb(1'b0, TBL[i][67:36], 8'h00, 4'h0);
      chk(rd, {24'h0, TBL[i][35:28]});
      settle(TBL[i][27:24], 1'b1);
      @(posedge sys_clk_i);
      src_r <= ~TBL[i][23:0];
      settle(TBL[i][27:24], 1'b0);
    end
  endtask : t_routes
  task tally_and_finish;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset(1'b0);
    t_refuse;
    t_routes;
    t_reset(1'b1);
    tally_and_finish;
  end
endmodule : tb_top
